// File: hdl/fpx_cond.sv
// Floating-point condition predicate evaluator
`timescale 1ns/100ps
module fpx_cond
  import fpx_pkg::*;
(
  // Condition codes
  input  wire logic   cc_n_i,
  input  wire logic   cc_z_i,
  // Predicate and verdict
  input  fpx_cond_type cond_i,
  output logic         true_o
);

  always_comb begin
    case (cond_i)
      C_F:     true_o = 1'b0;
      C_EQ:    true_o = cc_z_i;
      C_GT:    true_o = !cc_z_i && !cc_n_i;
      C_GE:    true_o = cc_z_i || !cc_n_i;
      C_LT:    true_o = cc_n_i && !cc_z_i;
      C_LE:    true_o = cc_z_i || cc_n_i;
      C_NE:    true_o = !cc_z_i;
      default: true_o = 1'b1;
    endcase
  end

endmodule : fpx_cond

// File: hdl/fpx_exec.sv
// Decode and execute of the integer and fp instruction slice
`timescale 1ns/100ps

//
// Overview of operation
// - Exchange swaps two full registers at once
// - Sign widen byte/word, result back in place
// - Magnitude of source into fp destination
// - Negate source into destination, also in place
// - Add, multiply, divide write back destination
// - Compare only sets codes, destination kept
// - Conditional branch adds displacement when true
// - Decrement branch: count down, stop at -1
// - Conditional set writes ones or zeros
// - State save supervisor only, else trap
// - State restore supervisor only, else trap
// - Long moves to or from control registers
// - Packed store takes register or immediate k
// - Multi move with static or dynamic list
// - Multi move of selected control registers
// - No-op changes no architectural state but the program counter
module fpx_exec
  import fpx_pkg::*;
(
  // Clock and reset
  input  wire logic     clk_i,
  input  wire logic     arst_n_i,
  // Instruction issue
  input  wire logic     instr_valid_i,
  input  fpx_instr_type instr_i,
  output logic          instr_ready_o,
  // Core state
  input  wire logic     super_i,
  input  wire logic     fpu_present_i,
  // Arithmetic unit
  output fpx_arith_type arith_o,
  input  wire logic     arith_done_i,
  input  wire logic [31:0] arith_res_i,
  // Memory port
  output fpx_mem_type   mem_o,
  input  wire logic     mem_ack_i,
  input  wire logic [31:0] mem_rdata_i,
  // Status
  output logic [31:0]   pc_o,
  output logic          done_o,
  output fpx_trap_type  trap_o,
  // Register observation
  input  wire logic [4:0] peek_sel_i,
  output logic [31:0]   peek_o
);

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_ARITH = 2'h1,
    ST_XFER  = 2'h2
  } fpx_state_type;

  fpx_state_type state_reg;
  fpx_state_type state_next;
  fpx_instr_type cur_reg;
  fpx_instr_type cur_next;
  fpx_arith_type arith_reg;
  fpx_arith_type arith_next;
  fpx_trap_type  trap_reg;
  fpx_trap_type  trap_next;
  logic [31:0]   pc_reg;
  logic [31:0]   pc_next;
  logic [31:0]   ireg_reg [IR_COUNT];
  logic [31:0]   ireg_next [IR_COUNT];
  logic [31:0]   xreg_reg [XR_COUNT];
  logic [31:0]   xreg_next [XR_COUNT];
  logic [12:0]   xlist_reg;
  logic [12:0]   xlist_next;
  logic [31:0]   addr_reg;
  logic [31:0]   addr_next;
  logic [31:0]   wdata_reg;
  logic [31:0]   wdata_next;
  logic          we_reg;
  logic          we_next;
  logic          req_reg;
  logic          req_next;
  logic          done_reg;
  logic          done_next;
  logic [31:0]   peek_reg;
  logic [31:0]   peek_next;
  logic          fpu_s1_reg;
  logic          fpu_s2_reg;

  logic          fin;
  logic          take_br;
  logic          start_x;
  logic [12:0]   xl;
  logic [31:0]   src_val;
  logic [31:0]   dst_val;
  logic [31:0]   dn;
  logic [15:0]   cnt;
  logic [3:0]    idx;
  logic          cond_true;

  // Sign extension by width selector
  function automatic logic [31:0] widen_f(
    input logic [31:0]   v,
    input fpx_widen_type w
  );
    case (w)
      W_B2W:   widen_f = {v[31:16], {8{v[7]}}, v[7:0]};
      W_W2L:   widen_f = {{16{v[15]}}, v[15:0]};
      default: widen_f = {{24{v[7]}}, v[7:0]};
    endcase
  endfunction : widen_f

  // Lowest pending register of a transfer list
  function automatic logic [3:0] low_f(input logic [12:0] m);
    low_f = 4'h0;
    for (int i = 12; i >= 0; i--) begin
      if (m[i]) begin
        low_f = 4'(i);
      end
    end
  endfunction : low_f

  // Fp class of an operation
  function automatic logic is_fp_f(input fpx_op_type op);
    is_fp_f = (op != OP_NOP) && (op != OP_SWAP) && (op != OP_WIDEN);
  endfunction : is_fp_f

  // Condition codes held in the status register
  fpx_cond u_cond (
    .cc_n_i (xreg_reg[XR_STATUS][CC_N_BIT]),
    .cc_z_i (xreg_reg[XR_STATUS][CC_Z_BIT]),
    .cond_i (instr_i.cond),
    .true_o (cond_true)
  );

  // Unit presence strap synchroniser
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fpu_s1_reg <= 1'b0;
      fpu_s2_reg <= 1'b0;
    end else begin
      fpu_s1_reg <= fpu_present_i;
      fpu_s2_reg <= fpu_s1_reg;
    end
  end

  always_comb begin
    state_next = state_reg;
    cur_next   = cur_reg;
    arith_next = arith_reg;
    pc_next    = pc_reg;
    ireg_next  = ireg_reg;
    xreg_next  = xreg_reg;
    xlist_next = xlist_reg;
    addr_next  = addr_reg;
    we_next    = we_reg;
    done_next  = 1'b0;
    trap_next  = TRAP_NONE;
    fin        = 1'b0;
    take_br    = 1'b0;
    start_x    = 1'b0;
    xl         = '0;
    dn         = ireg_reg[instr_i.rx];
    src_val    = instr_i.src_ea ? instr_i.ea_data
                                : xreg_reg[{1'b0, instr_i.fp_src}];
    dst_val    = xreg_reg[{1'b0, instr_i.fp_dst}];
    cnt        = dn[15:0] - 16'h0001;
    idx        = low_f(xlist_reg);
    arith_next.req = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (instr_valid_i) begin
          cur_next = instr_i;
          fin      = 1'b1;
          if (is_fp_f(instr_i.op) && !fpu_s2_reg) begin
            trap_next = TRAP_NOFPU;
          end else begin
            case (instr_i.op)
              OP_SWAP: begin
                ireg_next[instr_i.rx] = ireg_reg[instr_i.ry];
                ireg_next[instr_i.ry] = ireg_reg[instr_i.rx];
              end
              OP_WIDEN: begin
                ireg_next[instr_i.rx] = widen_f(dn, instr_i.widen);
              end
              OP_ABS: begin
                xreg_next[{1'b0, instr_i.fp_dst}] = {1'b0, src_val[30:0]};
              end
              OP_NEG: begin
                xreg_next[{1'b0, instr_i.fp_dst}] =
                  {~src_val[31], src_val[30:0]};
              end
              OP_ADD, OP_MUL, OP_DIV, OP_CMP: begin
                fin        = 1'b0;
                state_next = ST_ARITH;
                arith_next.req = 1'b1;
                arith_next.a   = dst_val;
                arith_next.b   = src_val;
                arith_next.k   = '0;
                case (instr_i.op)
                  OP_ADD:  arith_next.op = AR_ADD;
                  OP_MUL:  arith_next.op = AR_MUL;
                  OP_DIV:  arith_next.op = AR_DIV;
                  default: arith_next.op = AR_SUB;
                endcase
              end
              OP_BRANCH: begin
                take_br = cond_true;
              end
              OP_DBRANCH: begin
                if (!cond_true) begin
                  ireg_next[instr_i.rx] = {dn[31:16], cnt};
                  take_br = (cnt != CNT_END);
                end
              end
              OP_SET: begin
                ireg_next[instr_i.rx][7:0] =
                  cond_true ? SET_ONES : SET_ZEROS;
              end
              OP_SAVE, OP_RESTORE: begin
                if (!super_i) begin
                  trap_next = TRAP_PRIV;
                end else begin
                  start_x = 1'b1;
                  xl[XR_STATE] = 1'b1;
                  we_next = (instr_i.op == OP_SAVE);
                end
              end
              OP_MOVE: begin
                if (instr_i.to_mem) begin
                  start_x = 1'b1;
                  xl[{1'b0, instr_i.fp_src}] = 1'b1;
                  we_next = 1'b1;
                end else begin
                  xreg_next[{1'b0, instr_i.fp_dst}] = instr_i.ea_data;
                end
              end
              OP_MOVE_PACK: begin
                fin        = 1'b0;
                state_next = ST_ARITH;
                arith_next.req = 1'b1;
                arith_next.op  = AR_PACK;
                arith_next.a   = xreg_reg[{1'b0, instr_i.fp_src}];
                arith_next.b   = '0;
                arith_next.k   = instr_i.k_dyn ? dn[6:0] : instr_i.k_imm;
              end
              OP_MOVE_CTRL: begin
                start_x = 1'b1;
                xl[XR_CTRL + {2'b00, instr_i.ctrl_sel}] = 1'b1;
                we_next = instr_i.to_mem;
              end
              OP_MULTI: begin
                start_x  = 1'b1;
                xl[7:0]  = instr_i.list_dyn ? dn[7:0] : instr_i.list;
                we_next  = instr_i.to_mem;
              end
              OP_MULTI_CTRL: begin
                start_x  = 1'b1;
                xl[10:8] = instr_i.list[2:0];
                we_next  = instr_i.to_mem;
              end
              default: begin
                fin = 1'b1;
              end
            endcase
          end
        end
      end
      ST_ARITH: begin
        if (arith_done_i) begin
          fin        = 1'b1;
          state_next = ST_IDLE;
          if (cur_reg.op == OP_CMP) begin
            xreg_next[XR_STATUS][CC_N_BIT] = arith_res_i[31];
            xreg_next[XR_STATUS][CC_Z_BIT] = (arith_res_i == '0);
          end else if (cur_reg.op == OP_MOVE_PACK) begin
            xreg_next[XR_TEMP] = arith_res_i;
            fin     = 1'b0;
            start_x = 1'b1;
            xl[XR_TEMP] = 1'b1;
            we_next = 1'b1;
          end else begin
            xreg_next[{1'b0, cur_reg.fp_dst}] = arith_res_i;
          end
        end else begin
          arith_next.req = 1'b1;
        end
      end
      ST_XFER: begin
        if (mem_ack_i) begin
          if (!we_reg) begin
            xreg_next[idx] = mem_rdata_i;
          end
          xlist_next[idx] = 1'b0;
          addr_next = addr_reg + WORD_STEP;
          if (xlist_next == '0) begin
            fin        = 1'b1;
            state_next = ST_IDLE;
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (start_x) begin
      xlist_next = xl;
      addr_next  = cur_next.ea_addr;
      fin        = (xl == '0);
      state_next = (xl == '0) ? ST_IDLE : ST_XFER;
    end
    if (fin) begin
      done_next = 1'b1;
      pc_next   = take_br ? pc_reg + cur_next.disp : pc_reg + INSTR_STEP;
    end
    wdata_next = xreg_next[low_f(xlist_next)];
    req_next   = (state_next == ST_XFER);
    if (peek_sel_i < PEEK_XBASE) begin
      peek_next = ireg_reg[peek_sel_i[3:0]];
    end else if (peek_sel_i < PEEK_LIMIT) begin
      peek_next = xreg_reg[4'(peek_sel_i - PEEK_XBASE)];
    end else begin
      peek_next = '0;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= ST_IDLE;
      cur_reg   <= '0;
      arith_reg <= '0;
      trap_reg  <= TRAP_NONE;
      pc_reg    <= PC_RESET;
      xlist_reg <= '0;
      addr_reg  <= '0;
      wdata_reg <= '0;
      we_reg    <= 1'b0;
      req_reg   <= 1'b0;
      done_reg  <= 1'b0;
      peek_reg  <= '0;
      for (int i = 0; i < IR_COUNT; i++) begin
        ireg_reg[i] <= '0;
      end
      for (int i = 0; i < XR_COUNT; i++) begin
        xreg_reg[i] <= '0;
      end
    end else begin
      state_reg <= state_next;
      cur_reg   <= cur_next;
      arith_reg <= arith_next;
      trap_reg  <= trap_next;
      pc_reg    <= pc_next;
      xlist_reg <= xlist_next;
      addr_reg  <= addr_next;
      wdata_reg <= wdata_next;
      we_reg    <= we_next;
      req_reg   <= req_next;
      done_reg  <= done_next;
      peek_reg  <= peek_next;
      ireg_reg  <= ireg_next;
      xreg_reg  <= xreg_next;
    end
  end

  // Outputs
  assign instr_ready_o = (state_reg == ST_IDLE);
  assign arith_o       = arith_reg;
  assign mem_o         = '{req: req_reg, we: we_reg,
                           addr: addr_reg, wdata: wdata_reg};
  assign pc_o          = pc_reg;
  assign done_o        = done_reg;
  assign trap_o        = trap_reg;
  assign peek_o        = peek_reg;

endmodule : fpx_exec

// File: shared/fpx_pkg.sv
// Types and constants shared by the fp execute slice
package fpx_pkg;

  // Program counter
  localparam logic [31:0] PC_RESET   = 32'h0000_0000;
  localparam logic [31:0] INSTR_STEP = 32'h0000_0004;
  localparam logic [31:0] WORD_STEP  = 32'h0000_0004;

  // Extended register file: fp data, control, state, scratch
  localparam int          XR_COUNT   = 13;
  localparam logic [3:0]  XR_CTRL    = 4'h8;
  localparam logic [3:0]  XR_STATUS  = 4'h9;
  localparam logic [3:0]  XR_STATE   = 4'hb;
  localparam logic [3:0]  XR_TEMP    = 4'hc;
  localparam int          IR_COUNT   = 16;
  localparam logic [4:0]  PEEK_XBASE = 5'h10;
  localparam logic [4:0]  PEEK_LIMIT = 5'h1d;

  // Condition code bits inside the status register
  localparam int          CC_N_BIT   = 27;
  localparam int          CC_Z_BIT   = 26;

  // Loop counter end value and set patterns
  localparam logic [15:0] CNT_END    = 16'hffff;
  localparam logic [7:0]  SET_ONES   = 8'hff;
  localparam logic [7:0]  SET_ZEROS  = 8'h00;

  typedef enum logic [4:0] {
    OP_NOP        = 5'h00,
    OP_SWAP       = 5'h01,
    OP_WIDEN      = 5'h02,
    OP_ABS        = 5'h03,
    OP_NEG        = 5'h04,
    OP_ADD        = 5'h05,
    OP_MUL        = 5'h06,
    OP_DIV        = 5'h07,
    OP_CMP        = 5'h08,
    OP_BRANCH     = 5'h09,
    OP_DBRANCH    = 5'h0a,
    OP_SET        = 5'h0b,
    OP_SAVE       = 5'h0c,
    OP_RESTORE    = 5'h0d,
    OP_MOVE       = 5'h0e,
    OP_MOVE_PACK  = 5'h0f,
    OP_MOVE_CTRL  = 5'h10,
    OP_MULTI      = 5'h11,
    OP_MULTI_CTRL = 5'h12
  } fpx_op_type;

  typedef enum logic [1:0] {
    W_B2W = 2'h0,
    W_W2L = 2'h1,
    W_B2L = 2'h2
  } fpx_widen_type;

  typedef enum logic [2:0] {
    C_F  = 3'h0,
    C_EQ = 3'h1,
    C_GT = 3'h2,
    C_GE = 3'h3,
    C_LT = 3'h4,
    C_LE = 3'h5,
    C_NE = 3'h6,
    C_T  = 3'h7
  } fpx_cond_type;

  typedef enum logic [2:0] {
    AR_ADD  = 3'h0,
    AR_MUL  = 3'h1,
    AR_DIV  = 3'h2,
    AR_SUB  = 3'h3,
    AR_PACK = 3'h4
  } fpx_aop_type;

  typedef enum logic [1:0] {
    TRAP_NONE  = 2'h0,
    TRAP_PRIV  = 2'h1,
    TRAP_NOFPU = 2'h2
  } fpx_trap_type;

  typedef struct packed {
    fpx_op_type    op;
    logic [2:0]    fp_dst;
    logic [2:0]    fp_src;
    logic          src_ea;
    logic [3:0]    rx;
    logic [3:0]    ry;
    fpx_widen_type widen;
    fpx_cond_type  cond;
    logic          to_mem;
    logic          list_dyn;
    logic          k_dyn;
    logic [6:0]    k_imm;
    logic [7:0]    list;
    logic [1:0]    ctrl_sel;
    logic [31:0]   disp;
    logic [31:0]   ea_addr;
    logic [31:0]   ea_data;
  } fpx_instr_type;

  typedef struct packed {
    logic        req;
    fpx_aop_type op;
    logic [31:0] a;
    logic [31:0] b;
    logic [6:0]  k;
  } fpx_arith_type;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } fpx_mem_type;

endpackage : fpx_pkg

// File: verif/fpx_exec_properties.sv
// Port-level property checker for the fp execute slice
`timescale 1ns/100ps
module fpx_exec_properties
  import fpx_pkg::*;
(
  // Clock and reset
  input  wire logic    clk_i,
  input  wire logic    arst_n_i,
  // Issue and core state
  input  wire logic    instr_valid_i,
  input  fpx_instr_type instr_i,
  input  wire logic    instr_ready_o,
  input  wire logic    super_i,
  input  wire logic    fpu_present_i,
  // Arithmetic and memory ports
  input  fpx_arith_type arith_o,
  input  wire logic    arith_done_i,
  input  fpx_mem_type  mem_o,
  input  wire logic    mem_ack_i,
  // Status
  input  wire logic [31:0] pc_o,
  input  wire logic    done_o,
  input  fpx_trap_type trap_o
);
  logic [1:0] hist_reg;
  logic [1:0] hist_next;
  logic       take;
  logic       fp_ok;
  logic       no_fp;

  // History of the unit-present strap
  always_comb begin
    hist_next = {hist_reg[0], fpu_present_i};
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hist_reg <= 2'h0;
    end else begin
      hist_reg <= hist_next;
    end
  end
  assign take  = instr_valid_i && instr_ready_o;
  assign fp_ok = (hist_reg == 2'h3) && fpu_present_i;
  assign no_fp = (hist_reg == 2'h0) && !fpu_present_i;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  AST_BR_TAKEN: assert property (
    take && fp_ok && instr_i.op == OP_BRANCH && instr_i.cond == C_T
    |=> done_o && pc_o == $past(pc_o) + $past(instr_i.disp))
    else $error("true branch missed its target");
  AST_BR_NOT: assert property (
    take && fp_ok && instr_i.op == OP_BRANCH && instr_i.cond == C_F
    |=> done_o && pc_o == $past(pc_o) + INSTR_STEP)
    else $error("false branch did not fall through");
  AST_SAVE_PRIV: assert property (
    take && !super_i && instr_i.op == OP_SAVE
    |=> done_o && trap_o != TRAP_NONE && !mem_o.req)
    else $error("user state save not trapped");
  AST_RESTORE_PRIV: assert property (
    take && !super_i && instr_i.op == OP_RESTORE
    |=> done_o && trap_o != TRAP_NONE && !mem_o.req)
    else $error("user state restore not trapped");
  AST_NO_UNIT: assert property (
    take && no_fp && instr_i.op inside {OP_ABS, OP_ADD, OP_CMP, OP_SET}
    |=> done_o && trap_o == TRAP_NOFPU)
    else $error("fp op ran without the unit");
  AST_ADD_REQ: assert property (
    take && fp_ok && instr_i.op == OP_ADD
    |=> arith_o.req && arith_o.op == AR_ADD)
    else $error("add not sent to arithmetic port");
  AST_CMP_SUB: assert property (
    take && fp_ok && instr_i.op == OP_CMP
    |=> arith_o.req && arith_o.op == AR_SUB && !done_o)
    else $error("compare not sent as subtract");
  AST_PACK_K: assert property (
    take && fp_ok && instr_i.op == OP_MOVE_PACK && !instr_i.k_dyn
    |=> arith_o.req && arith_o.k == $past(instr_i.k_imm))
    else $error("packed store lost immediate factor");
  AST_ARITH_HOLD: assert property (
    arith_o.req && !arith_done_i |=> $stable(arith_o) && !done_o)
    else $error("arithmetic request changed before done");
  AST_MEM_HOLD: assert property (
    mem_o.req && !mem_ack_i |=> $stable(mem_o))
    else $error("memory request changed before ack");
  AST_READY_BUSY: assert property (
    arith_o.req || mem_o.req |-> !instr_ready_o)
    else $error("ready raised while a request is pending");
endmodule : fpx_exec_properties

// File: verif/testbench.sv
// Self-checking bench for the fp execute slice
`timescale 1ns/100ps
module testbench
  import fpx_pkg::*;
;
  logic          clk_i    = 1'b0;
  logic          arst_n_i = 1'b0;
  logic          valid    = 1'b0;
  fpx_instr_type instr    = '0;
  logic          sup      = 1'b1;
  logic          fpu_on   = 1'b1;
  logic          a_done   = 1'b0;
  logic          a_wait   = 1'b0;
  logic [31:0]   a_res    = 32'h0;
  logic          m_ack    = 1'b0;
  logic          m_wait   = 1'b0;
  logic [31:0]   m_rdata  = 32'h0;
  logic [4:0]    sel      = 5'h00;
  logic          ready;
  fpx_arith_type arith;
  fpx_arith_type a_seen;
  fpx_mem_type   mem;
  logic [31:0]   pc;
  logic          done;
  fpx_trap_type  trap;
  logic [31:0]   peek;
  logic [31:0]   pc_exp   = 32'h0;
  logic [31:0]   wmem [logic [31:0]];
  int            n_mismatch = 0;
  int            n_tests    = 0;
  int            cycles     = 0;

  always #2 clk_i = ~clk_i;

  fpx_exec DUT (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .instr_valid_i(valid), .instr_i(instr), .instr_ready_o(ready),
    .super_i(sup), .fpu_present_i(fpu_on), .arith_o(arith),
    .arith_done_i(a_done), .arith_res_i(a_res), .mem_o(mem),
    .mem_ack_i(m_ack), .mem_rdata_i(m_rdata), .pc_o(pc), .done_o(done),
    .trap_o(trap), .peek_sel_i(sel), .peek_o(peek));

  function automatic logic [31:0] rd(logic [31:0] a);
    return a * 32'h9e37_79b1;
  endfunction : rd

  function automatic logic [31:0] f(int k);
    return rd(32'h100 + 32'(k) * 32'h4);
  endfunction : f

  function automatic logic [31:0] alu(fpx_arith_type a);
    case (a.op)
      AR_ADD:  return a.a + a.b;
      AR_MUL:  return a.a * a.b;
      AR_DIV:  return a.a ^ a.b;
      AR_SUB:  return a.a - a.b;
      default: return ~a.a;
    endcase
  endfunction : alu

  function automatic logic [31:0] nx();
    return pc_exp + INSTR_STEP;
  endfunction : nx

  function automatic fpx_instr_type mk(fpx_op_type o, logic [3:0] x,
                                       logic [3:0] y, logic [2:0] c);
    fpx_instr_type i;
    i = '0;
    i.op = o;
    i.rx = x;
    i.ry = y;
    i.fp_dst = x[2:0];
    i.fp_src = y[2:0];
    i.cond = fpx_cond_type'(c);
    i.widen = fpx_widen_type'(c[1:0]);
    i.ea_addr = 32'h0000_0100;
    i.disp = 32'h0000_0040;
    return i;
  endfunction : mk

  // Arithmetic unit and memory answering after one wait cycle
  always @(posedge clk_i) begin
    a_done <= 1'b0;
    m_ack <= 1'b0;
    if (arith.req && !a_done && !a_wait) begin
      a_wait <= 1'b1;
    end else if (a_wait) begin
      a_wait <= 1'b0;
      a_done <= 1'b1;
      a_res <= alu(arith);
      a_seen = arith;
    end
    if (mem.req && !m_ack && !m_wait) begin
      m_wait <= 1'b1;
    end else if (m_wait) begin
      m_wait <= 1'b0;
      m_ack <= 1'b1;
      m_rdata <= rd(mem.addr);
      if (mem.we) wmem[mem.addr] = mem.wdata;
    end
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 6000) begin
      n_mismatch++;
      close_out();
    end
  end

  task automatic chk(logic [31:0] got, logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic run(fpx_instr_type i, logic [31:0] npc, fpx_trap_type t);
    int k;
    @(posedge clk_i);
    valid <= 1'b1;
    instr <= i;
    @(posedge clk_i);
    valid <= 1'b0;
    k = 0;
    #1;
    while (done !== 1'b1 && k < 100) begin
      @(posedge clk_i);
      #1;
      k++;
    end
    chk({31'h0, done}, 32'h1);
    chk(pc, npc);
    chk(32'(trap), 32'(t));
    pc_exp = npc;
  endtask : run

  task automatic look(logic [4:0] s, logic [31:0] exp);
    @(posedge clk_i);
    sel <= s;
    @(posedge clk_i);
    #1;
    chk(peek, exp);
  endtask : look

  task automatic t_int();
    run(mk(OP_SET, 4'h3, 4'h0, C_T), nx(), TRAP_NONE);
    run(mk(OP_WIDEN, 4'h3, 4'h0, 3'h0), nx(), TRAP_NONE);
    run(mk(OP_WIDEN, 4'h3, 4'h0, 3'h1), nx(), TRAP_NONE);
    look(5'h03, 32'hffff_ffff);
    run(mk(OP_SET, 4'h3, 4'h0, C_F), nx(), TRAP_NONE);
    look(5'h03, 32'hffff_ff00);
    run(mk(OP_WIDEN, 4'h3, 4'h0, 3'h2), nx(), TRAP_NONE);
    look(5'h03, 32'h0000_0000);
    run(mk(OP_SET, 4'h1, 4'h0, C_T), nx(), TRAP_NONE);
    run(mk(OP_WIDEN, 4'h1, 4'h0, 3'h2), nx(), TRAP_NONE);
    run(mk(OP_SWAP, 4'h1, 4'ha, 3'h0), nx(), TRAP_NONE);
    look(5'h0a, 32'hffff_ffff);
    run(mk(OP_SWAP, 4'h3, 4'ha, 3'h0), nx(), TRAP_NONE);
    look(5'h03, 32'hffff_ffff);
    look(5'h0a, 32'h0000_0000);
    $display("Test integer ops finished");
  endtask : t_int

  task automatic t_mm();
    fpx_instr_type i;
    i = mk(OP_MULTI, 4'h0, 4'h0, 3'h0);
    i.list = 8'hff;
    run(i, nx(), TRAP_NONE);
    for (int k = 0; k < 8; k++) look(5'(16 + k), f(k));
    run(mk(OP_SET, 4'h5, 4'h0, C_T), nx(), TRAP_NONE);
    i.list_dyn = 1'b1;
    i.rx = 4'h5;
    i.to_mem = 1'b1;
    i.ea_addr = 32'h200;
    run(i, nx(), TRAP_NONE);
    for (int k = 0; k < 8; k++) chk(wmem[32'h200 + 4 * k], f(k));
    $display("Test multi move finished");
  endtask : t_mm

  task automatic t_ar();
    run(mk(OP_NEG, 4'h3, 4'h2, 3'h0), nx(), TRAP_NONE);
    look(5'h13, f(2) ^ 32'h8000_0000);
    run(mk(OP_ABS, 4'h1, 4'h3, 3'h0), nx(), TRAP_NONE);
    run(mk(OP_ABS, 4'h4, 4'h2, 3'h0), nx(), TRAP_NONE);
    look(5'h11, f(2) & 32'h7fff_ffff);
    look(5'h14, f(2) & 32'h7fff_ffff);
    run(mk(OP_NEG, 4'h5, 4'h5, 3'h0), nx(), TRAP_NONE);
    look(5'h15, f(5) ^ 32'h8000_0000);
    run(mk(OP_ADD, 4'h6, 4'h7, 3'h0), nx(), TRAP_NONE);
    look(5'h16, f(6) + f(7));
    run(mk(OP_MUL, 4'h0, 4'h7, 3'h0), nx(), TRAP_NONE);
    look(5'h10, f(0) * f(7));
    run(mk(OP_DIV, 4'h7, 4'h0, 3'h0), nx(), TRAP_NONE);
    look(5'h17, f(7) ^ (f(0) * f(7)));
    run(mk(OP_CMP, 4'h6, 4'h6, 3'h0), nx(), TRAP_NONE);
    chk(32'(a_seen.op), 32'(AR_SUB));
    look(5'h16, f(6) + f(7));
    $display("Test arithmetic finished");
  endtask : t_ar

  task automatic t_br();
    logic [7:0] tv;
    tv = 8'haa;
    for (int c = 0; c < 8; c++) begin
      run(mk(OP_BRANCH, 4'h0, 4'h0, 3'(c)),
          tv[c] ? pc_exp + 32'h40 : nx(), TRAP_NONE);
    end
    $display("Test branch finished");
  endtask : t_br

  task automatic t_db();
    run(mk(OP_SET, 4'h3, 4'h0, C_F), nx(), TRAP_NONE);
    run(mk(OP_WIDEN, 4'h3, 4'h0, 3'h0), nx(), TRAP_NONE);
    run(mk(OP_DBRANCH, 4'h3, 4'h0, C_T), nx(), TRAP_NONE);
    look(5'h03, 32'hffff_0000);
    run(mk(OP_DBRANCH, 4'h3, 4'h0, C_F), nx(), TRAP_NONE);
    look(5'h03, 32'hffff_ffff);
    run(mk(OP_DBRANCH, 4'h3, 4'h0, C_F), pc_exp+32'h40, TRAP_NONE);
    look(5'h03, 32'hffff_fffe);
    $display("Test decrement branch finished");
  endtask : t_db

  task automatic t_sv();
    fpx_instr_type i;
    i = mk(OP_RESTORE, 4'h0, 4'h0, 3'h0);
    i.ea_addr = 32'h300;
    run(i, nx(), TRAP_NONE);
    look(5'h1b, rd(32'h300));
    i.op = OP_SAVE;
    i.ea_addr = 32'h400;
    run(i, nx(), TRAP_NONE);
    chk(wmem[32'h400], rd(32'h300));
    @(posedge clk_i);
    sup <= 1'b0;
    run(i, nx(), TRAP_PRIV);
    i.op = OP_RESTORE;
    i.ea_addr = 32'h500;
    run(i, nx(), TRAP_PRIV);
    look(5'h1b, rd(32'h300));
    @(posedge clk_i);
    sup <= 1'b1;
    i = mk(OP_MOVE_CTRL, 4'h0, 4'h0, 3'h0);
    i.ea_addr = 32'h700;
    run(i, nx(), TRAP_NONE);
    look(5'h18, rd(32'h700));
    i.to_mem = 1'b1;
    i.ea_addr = 32'h704;
    run(i, nx(), TRAP_NONE);
    chk(wmem[32'h704], rd(32'h700));
    i = mk(OP_MULTI_CTRL, 4'h0, 4'h0, 3'h0);
    i.list = 8'h05;
    i.ea_addr = 32'h900;
    run(i, nx(), TRAP_NONE);
    look(5'h18, rd(32'h900));
    look(5'h1a, rd(32'h904));
    i.to_mem = 1'b1;
    i.ea_addr = 32'ha00;
    run(i, nx(), TRAP_NONE);
    chk(wmem[32'ha04], rd(32'h904));
    i = mk(OP_MOVE_PACK, 4'h3, 4'h1, 3'h0);
    i.k_imm = 7'h05;
    i.ea_addr = 32'h800;
    run(i, nx(), TRAP_NONE);
    chk(32'(a_seen.k), 32'h5);
    chk(wmem[32'h800], ~(f(2) & 32'h7fff_ffff));
    i.k_dyn = 1'b1;
    run(i, nx(), TRAP_NONE);
    chk(32'(a_seen.k), 32'h7e);
    $display("Test state and moves finished");
  endtask : t_sv

  task automatic t_nf();
    run(mk(OP_NOP, 4'h6, 4'h0, 3'h0), nx(), TRAP_NONE);
    look(5'h16, f(6) + f(7));
    @(posedge clk_i);
    fpu_on <= 1'b0;
    repeat (3) @(posedge clk_i);
    run(mk(OP_ABS, 4'h6, 4'h0, 3'h0), nx(), TRAP_NOFPU);
    look(5'h16, f(6) + f(7));
    $display("Test no-op and absent unit finished");
  endtask : t_nf

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (3) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    t_int();
    t_mm();
    t_ar();
    t_br();
    t_db();
    t_sv();
    t_nf();
    close_out();
  end
endmodule : testbench

bind fpx_exec fpx_exec_properties u_prop (.clk_i(clk_i),
  .arst_n_i(arst_n_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
  .instr_ready_o(instr_ready_o), .super_i(super_i),
  .fpu_present_i(fpu_present_i), .arith_o(arith_o),
  .arith_done_i(arith_done_i), .mem_o(mem_o), .mem_ack_i(mem_ack_i),
  .pc_o(pc_o), .done_o(done_o), .trap_o(trap_o));
